// ### inc/asp_pkg.sv
package asp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TXD_OFS = 8'h08;
  localparam logic [7:0] RXD_OFS = 8'h0C;
  localparam logic [7:0] DIV_OFS = 8'h10;
  localparam logic [7:0] IRQ_OFS = 8'h14;
  localparam logic [7:0] MASK_OFS = 8'h18;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_BITS8 = 0;
  localparam int CTRL_PAR_LO = 1;
  localparam int CTRL_FLOW = 3;
  localparam int CTRL_TERM = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;
  localparam logic [15:0] DIV_RST = 16'h01B2;
  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_RXDONE = 0;
  localparam int IRQ_TXDONE = 1;
  localparam int IRQ_FRAME = 2;
  localparam int IRQ_OVER = 3;
  localparam int IRQ_PARITY = 4;
  localparam int IRQ_W = 5;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_DEF = 115_200;
  localparam int DIV_MIN = 4;

  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} asp_par_e;

  typedef struct packed {
    logic bits8;
    asp_par_e par;
    logic flow;
    logic term;
  } asp_cfg_s;

  // Odd or even parity bit, as p selects (even only for PAR_EVEN), for the active data bits
  function automatic logic asp_parity(input logic [7:0] d, input logic bits8, input asp_par_e p);
    logic x;
    x = ^d[6:0] ^ (bits8 & d[7]);
    return (p == PAR_EVEN) ? x : ~x;
  endfunction
endpackage

// ### verilog/asp_rx.sv
`timescale 1ns/1ps
module asp_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] div,
  input wire asp_pkg::asp_cfg_s cfg,
  input wire logic rx_line,
  output logic done,
  output logic [7:0] data,
  output logic frame_err,
  output logic par_err
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT, RX_STOP} asp_rxst_e;
  typedef struct packed {
    asp_rxst_e st;
    logic [15:0] cnt;
    logic [3:0] nbit;
    logic [8:0] sh;
    logic done;
    logic [7:0] data;
    logic ferr;
    logic perr;
    logic prev;
  } asp_rxs_s;

  asp_rxs_s s_reg, s_next;
  logic [3:0] nbits;
  logic [8:0] al;

  always_comb begin
    nbits = 4'(cfg.bits8 ? 8 : 7) + 4'(cfg.par != asp_pkg::PAR_NONE ? 1 : 0);
    // Shifted bits sit at the top of the register; bring them down to bit 0
    al = s_reg.sh >> (4'h9 - nbits);
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.prev = rx_line;
    unique case (s_reg.st)
      RX_IDLE: begin
        if (s_reg.prev && !rx_line) begin
          s_next.st = RX_START;
          s_next.cnt = {1'b0, div[15:1]};
        end
      end
      RX_START: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.st = rx_line ? RX_IDLE : RX_SHIFT;
          s_next.cnt = div - 16'h0001;
          s_next.nbit = 4'h0;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      RX_SHIFT: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.sh = {rx_line, s_reg.sh[8:1]};
          s_next.cnt = div - 16'h0001;
          s_next.nbit = s_reg.nbit + 4'h1;
          if (s_reg.nbit + 4'h1 == nbits) begin
            s_next.st = RX_STOP;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      RX_STOP: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.st = RX_IDLE;
          s_next.done = 1'b1;
          s_next.data = cfg.bits8 ? al[7:0] : {1'b0, al[6:0]};
          s_next.ferr = !rx_line;
          s_next.perr = (cfg.par != asp_pkg::PAR_NONE) &&
            (asp_pkg::asp_parity(al[7:0], cfg.bits8, cfg.par) != (cfg.bits8 ? al[8] : al[7]));
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: RX_IDLE, prev: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign data = s_reg.data;
  assign frame_err = s_reg.ferr;
  assign par_err = s_reg.perr;

  a_rx_idle_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.st == RX_IDLE && s_reg.prev && !rx_line) |=> s_reg.st == RX_START)
    else $error("rx did not start on falling edge");
endmodule // asp_rx

// ### verilog/asp_top.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Frame: start 0, data lsb first, optional parity, stop 1.
// - Start falling edge launches timer; bits sampled mid-cell.
// - Line held high one full bit time after data or parity.
// - Transmitter idles with output high.
// - Flow control: assert rts, wait for cts before shifting data.
// - Without flow control send at once, no line checks.
// - Seven or eight data bits, one stop bit.
// - Parity odd/none native, odd/even/none terminal mode.
module asp_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic cts,
  output logic txd,
  output logic rts,
  output logic irq
);
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} asp_txst_e;
  typedef struct packed {
    logic [1:0] rs;
    logic [1:0] rxs;
    logic [1:0] ctss;
    logic [4:0] ctrl;
    logic [15:0] div;
    logic [4:0] irq_st;
    logic [4:0] mask;
    logic [7:0] rxbuf;
    logic rxfull;
    logic [7:0] txbuf;
    logic txfull;
    asp_txst_e tst;
    logic [15:0] tcnt;
    logic [3:0] tleft;
    logic [10:0] tsh;
    logic txd;
    logic rts;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } asp_st_s;

  asp_st_s s_reg, s_next;
  asp_pkg::asp_cfg_s cfg;
  logic rst_n;
  logic rx_done, rx_ferr, rx_perr;
  logic [7:0] rx_data;
  logic acc, fin, wr, rd;
  logic [4:0] ev;
  logic [3:0] flen;

  assign rst_n = s_reg.rs[1];
  assign cfg.bits8 = s_reg.ctrl[asp_pkg::CTRL_BITS8];
  assign cfg.flow = s_reg.ctrl[asp_pkg::CTRL_FLOW];
  assign cfg.term = s_reg.ctrl[asp_pkg::CTRL_TERM];
  // even parity only in terminal mode
  assign cfg.par = (s_reg.ctrl[2:1] == 2'h2 && s_reg.ctrl[asp_pkg::CTRL_TERM]) ? asp_pkg::PAR_EVEN :
    (s_reg.ctrl[2:1] == 2'h1) ? asp_pkg::PAR_ODD : asp_pkg::PAR_NONE;

  asp_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .div(s_reg.div),
    .cfg(cfg),
    .rx_line(s_reg.rxs[1]),
    .done(rx_done),
    .data(rx_data),
    .frame_err(rx_ferr),
    .par_err(rx_perr)
  );

  assign acc = psel && penable && !s_reg.pready;
  // Writes and read side effects land only at the edge that completes the transfer
  assign fin = psel && penable && s_reg.pready;
  assign wr = fin && pwrite;
  assign rd = fin && !pwrite;

  always_comb begin
    s_next = s_reg;
    s_next.rs = {s_reg.rs[0], 1'b1};
    s_next.rxs = {s_reg.rxs[0], rxd};
    s_next.ctss = {s_reg.ctss[0], cts};
    s_next.pready = acc;
    s_next.pslverr = 1'b0;
    ev = '0;
    // frame length: start + data + parity
    flen = 4'(cfg.bits8 ? 9 : 8) + 4'(cfg.par != asp_pkg::PAR_NONE ? 1 : 0);
    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    if (acc) begin
      s_next.prdata = '0;
      unique case (paddr)
        asp_pkg::CTRL_OFS: s_next.prdata = 32'(s_reg.ctrl);
        asp_pkg::STAT_OFS: s_next.prdata = {28'h0000000, s_reg.rts, s_reg.tst != TX_IDLE, s_reg.txfull, s_reg.rxfull};
        asp_pkg::TXD_OFS: s_next.prdata = 32'(s_reg.txbuf);
        asp_pkg::RXD_OFS: s_next.prdata = 32'(s_reg.rxbuf);
        asp_pkg::DIV_OFS: s_next.prdata = 32'(s_reg.div);
        asp_pkg::IRQ_OFS: s_next.prdata = 32'(s_reg.irq_st);
        asp_pkg::MASK_OFS: s_next.prdata = 32'(s_reg.mask);
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (rd && paddr == asp_pkg::RXD_OFS) s_next.rxfull = 1'b0;
    if (wr) begin
      unique case (paddr)
        asp_pkg::CTRL_OFS: s_next.ctrl = pwdata[4:0];
        asp_pkg::STAT_OFS, asp_pkg::RXD_OFS: ;
        asp_pkg::TXD_OFS: begin
          if (!s_reg.txfull) begin
            s_next.txbuf = pwdata[7:0];
            s_next.txfull = 1'b1;
          end
        end
        asp_pkg::DIV_OFS: begin
          if (pwdata[15:0] >= 16'(asp_pkg::DIV_MIN)) s_next.div = pwdata[15:0];
        end
        asp_pkg::IRQ_OFS: s_next.irq_st = s_reg.irq_st & ~pwdata[4:0];
        asp_pkg::MASK_OFS: s_next.mask = pwdata[4:0];
        default: ;
      endcase
    end
    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    if (rx_done) begin
      if (s_next.rxfull) ev[asp_pkg::IRQ_OVER] = 1'b1;
      s_next.rxbuf = rx_data;
      s_next.rxfull = 1'b1;
      ev[asp_pkg::IRQ_RXDONE] = 1'b1;
      ev[asp_pkg::IRQ_FRAME] = rx_ferr;
      ev[asp_pkg::IRQ_PARITY] = rx_perr;
    end
    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    unique case (s_reg.tst)
      TX_IDLE: begin
        s_next.txd = 1'b1;
        s_next.rts = 1'b0;
        if (s_reg.txfull) begin
          s_next.tsh = cfg.bits8 ?
            {1'b1, asp_pkg::asp_parity(s_reg.txbuf, 1'b1, cfg.par), s_reg.txbuf, 1'b0} :
            {2'b11, asp_pkg::asp_parity(s_reg.txbuf, 1'b0, cfg.par), s_reg.txbuf[6:0], 1'b0};
          if (cfg.par == asp_pkg::PAR_NONE) s_next.tsh[flen] = 1'b1;
          s_next.txfull = 1'b0;
          // Count includes the stop bit, so it lasts a whole bit time before idle
          s_next.tleft = flen + 4'h1;
          s_next.rts = cfg.flow;
          s_next.tst = cfg.flow ? TX_WAIT : TX_SHIFT;
          s_next.tcnt = '0;
        end
      end
      TX_WAIT: begin
        if (s_reg.ctss[1]) s_next.tst = TX_SHIFT;
      end
      TX_SHIFT: begin
        if (s_reg.tcnt == 16'h0000) begin
          s_next.txd = s_reg.tsh[0];
          s_next.tsh = {1'b1, s_reg.tsh[10:1]};
          s_next.tcnt = s_reg.div - 16'h0001;
          s_next.tleft = s_reg.tleft - 4'h1;
          // stop bit lasts full bit time
          if (s_reg.tleft == 4'h0) begin
            s_next.tst = TX_IDLE;
            s_next.rts = 1'b0;
            ev[asp_pkg::IRQ_TXDONE] = 1'b1;
            s_next.txd = 1'b1;
          end
        end else begin
          s_next.tcnt = s_reg.tcnt - 16'h0001;
        end
      end
      default: s_next.tst = TX_IDLE;
    endcase
    // Set wins over a same-cycle clear
    s_next.irq_st = s_next.irq_st | ev;
    s_next.irq = |(s_next.irq_st & s_next.mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{ctrl: asp_pkg::CTRL_RST, div: asp_pkg::DIV_RST, tst: TX_IDLE,
        rxs: 2'b11, txd: 1'b1, tsh: 11'h7FF, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign txd = s_reg.txd;
  assign rts = s_reg.rts;
  assign irq = s_reg.irq;

  a_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tst == TX_IDLE && $past(s_reg.tst) == TX_IDLE) |-> txd)
    else $error("tx line not high while idle");
  a_flow_wait_cts: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tst == TX_WAIT && !s_reg.ctss[1]) |=> s_reg.tst == TX_WAIT && txd)
    else $error("sent without clear to send");
  a_flow_rts_on: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tst == TX_WAIT) |-> rts)
    else $error("rts low while waiting");
  a_noflow_direct: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tst == TX_IDLE && s_reg.txfull && !cfg.flow) |=> s_reg.tst == TX_SHIFT)
    else $error("tx delayed without flow control");
  a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.tst == TX_SHIFT && $past(s_reg.tst) != TX_SHIFT) |=> !txd)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ev[asp_pkg::IRQ_TXDONE]) |-> s_reg.txd)
    else $error("stop bit not high");
  a_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_done && s_reg.rxfull && !rd) |=> s_reg.irq_st[asp_pkg::IRQ_OVER])
    else $error("overrun not flagged");
  a_even_term: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.par == asp_pkg::PAR_EVEN) |-> cfg.term)
    else $error("even parity outside terminal mode");
  a_frame_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_done && rx_ferr) |=> s_reg.irq_st[asp_pkg::IRQ_FRAME])
    else $error("framing error not flagged");
  c_tx_frame: cover property (@(posedge clk) ev[asp_pkg::IRQ_TXDONE]);
  c_rx_frame: cover property (@(posedge clk) rx_done);
  c_flow_wait: cover property (@(posedge clk) s_reg.tst == TX_WAIT ##1 s_reg.tst == TX_SHIFT);
  c_irq: cover property (@(posedge clk) irq);
endmodule // asp_top

// ### test/asp_peer.sv
`timescale 1ns/1ps
module asp_peer #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic rts,
  input wire logic cts_en,
  input wire logic [3:0] nbits,
  output logic rxd,
  output logic cts
);
  logic [9:0] frame;
  int n_frames = 0;

  initial rxd = 1'b1;
  initial cts = 1'b0;

  always @(posedge clk) begin
    cts <= rts & cts_en;
  end

  // ----------------------------------------------------------------
  // Receive side: capture every bit after the start bit
  // ----------------------------------------------------------------
  // mid-bit sampling
  initial forever begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge clk);
    frame = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (DIV) @(posedge clk);
      frame[i] = txd;
    end
    n_frames++;
  end

  // ----------------------------------------------------------------
  // Send side
  // ----------------------------------------------------------------
  // frame then idle
  task automatic send(input logic [7:0] d, input int nd, input logic hp, input logic p, input logic stop);
    @(posedge clk) rxd <= 1'b0;
    for (int i = 0; i < nd; i++) begin
      repeat (DIV) @(posedge clk);
      rxd <= d[i];
    end
    if (hp) begin
      repeat (DIV) @(posedge clk);
      rxd <= p;
    end
    repeat (DIV) @(posedge clk);
    rxd <= stop;
    repeat (DIV) @(posedge clk);
    rxd <= 1'b1;
    // A full idle bit keeps the next start edge clean
    repeat (DIV) @(posedge clk);
  endtask
endmodule // asp_peer

// ### test/test_async_serial_port_framing.sv
`timescale 1ns/1ps
module test_async_serial_port_framing;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, rxd, cts, txd, rts, irq, cts_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] nbits;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  asp_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts(cts), .txd(txd),
    .rts(rts), .irq(irq));
  asp_peer #(.DIV(8)) u_peer (.clk(clk), .txd(txd), .rts(rts), .cts_en(cts_en), .nbits(nbits), .rxd(rxd),
    .cts(cts));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task print_verdict;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the global timeout ends this wait
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mk);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & mk, exp);
  endtask

  task wait_frame(input int n0);
    while (u_peer.n_frames == n0) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [31:0] r;
    logic e;
    chk({30'h0, txd, rts}, 32'h2);
    rd_chk(asp_pkg::CTRL_OFS, 32'h1, 32'h1F);
    rd_chk(asp_pkg::DIV_OFS, 32'(asp_pkg::DIV_RST), 32'hFFFF);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(asp_pkg::DIV_OFS, 32'h8);
    wr(asp_pkg::DIV_OFS, 32'h3);
    rd_chk(asp_pkg::DIV_OFS, 32'h8, 32'hFFFF);
  endtask

  task t_tx;
    logic [4:0] cfgs [5] = '{5'h01, 5'h02, 5'h13, 5'h15, 5'h05};
    logic [7:0] d, mk;
    logic [1:0] m;
    logic hp, x, p;
    int nd, n0;
    d = 8'hA5;
    for (int i = 0; i < 5; i++) begin
      m = cfgs[i][2:1];
      nd = cfgs[i][0] ? 8 : 7;
      mk = cfgs[i][0] ? 8'hFF : 8'h7F;
      hp = (m == 2'h1) || (m == 2'h2 && cfgs[i][4]);
      x = ^(d & mk);
      p = (m == 2'h2) ? x : ~x;
      nbits <= 4'(nd + hp + 1);
      wr(asp_pkg::CTRL_OFS, 32'(cfgs[i]));
      n0 = u_peer.n_frames;
      wr(asp_pkg::TXD_OFS, 32'(d));
      wait_frame(n0);
      chk(32'(u_peer.frame), 32'(d & mk) | (32'(p & hp) << nd) | (32'h1 << (nd + hp)));
      repeat (12) @(posedge clk);
      chk({31'h0, txd}, 32'h1);
    end
  endtask

  task t_rx;
    wr(asp_pkg::CTRL_OFS, 32'h03);
    wr(asp_pkg::IRQ_OFS, 32'h1F);
    wr(asp_pkg::MASK_OFS, 32'h01);
    u_peer.send(8'h3C, 8, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk(asp_pkg::IRQ_OFS, 32'h01, 32'h1D);
    chk({31'h0, irq}, 32'h1);
    rd_chk(asp_pkg::RXD_OFS, 32'h3C, 32'hFF);
    wr(asp_pkg::IRQ_OFS, 32'h1F);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    u_peer.send(8'h3C, 8, 1'b1, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk(asp_pkg::IRQ_OFS, 32'h10, 32'h10);
    rd_chk(asp_pkg::RXD_OFS, 32'h3C, 32'hFF);
    wr(asp_pkg::IRQ_OFS, 32'h1F);
    wr(asp_pkg::MASK_OFS, 32'h00);
    u_peer.send(8'h55, 8, 1'b1, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rd_chk(asp_pkg::IRQ_OFS, 32'h04, 32'h04);
    chk({31'h0, irq}, 32'h0);
    rd_chk(asp_pkg::RXD_OFS, 32'h55, 32'hFF);
    wr(asp_pkg::IRQ_OFS, 32'h1F);
    u_peer.send(8'h11, 8, 1'b1, 1'b1, 1'b1);
    u_peer.send(8'h11, 8, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk(asp_pkg::IRQ_OFS, 32'h08, 32'h08);
    rd_chk(asp_pkg::RXD_OFS, 32'h11, 32'hFF);
    wr(asp_pkg::CTRL_OFS, 32'h14);
    wr(asp_pkg::IRQ_OFS, 32'h1F);
    u_peer.send(8'h2A, 7, 1'b1, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk(asp_pkg::IRQ_OFS, 32'h01, 32'h1D);
    rd_chk(asp_pkg::RXD_OFS, 32'h2A, 32'hFF);
  endtask

  task t_flow;
    int n0;
    nbits <= 4'h9;
    wr(asp_pkg::CTRL_OFS, 32'h09);
    n0 = u_peer.n_frames;
    wr(asp_pkg::TXD_OFS, 32'h5A);
    repeat (60) @(posedge clk);
    chk({30'h0, rts, txd}, 32'h3);
    chk(32'(u_peer.n_frames), 32'(n0));
    rd_chk(asp_pkg::STAT_OFS, 32'hC, 32'hE);
    cts_en <= 1'b1;
    wait_frame(n0);
    chk(32'(u_peer.frame), 32'h15A);
    repeat (20) @(posedge clk);
    chk({31'h0, rts}, 32'h0);
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cts_en = 1'b0;
    nbits = 4'hA;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_tx();
    t_rx();
    t_flow();
    print_verdict();
  end
endmodule // test_async_serial_port_framing
